// ---- verilog/hmcpd_top.sv ----
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - Per channel pattern select: 00 normal, 01 all ones, 10 PRBS, 11 power down.
// - Select 01 puts attenuator in receive path, broad bandwidth, 64-bit FIFO.
// - Select 10 puts attenuator in receive path, narrow bandwidth, 128-bit FIFO.
// - Select 11 puts attenuator in transmit path, narrow bandwidth, 128-bit FIFO.
// - Per receiver monitor gain: low gives 0 dB, high gives 26 dB.
// - Per channel loopback: 00 none, 01 analog, 10 digital, 11 remote.
// - No in-band loopback while hardware control mode is selected.
// - Tri-state input low enables both line drivers.
// - Tri-state input high puts both line drivers in high impedance.
// - Edge select 0 makes the rising edge active on recovered receive clocks.
// - Edge select 1 makes the falling edge active on recovered receive clocks.
module hmcpd_top #(
   parameter int NCH = hmcpd_pkg::HMCPD_NCH
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               hw_mode_select,
   input  wire logic [2*NCH-1:0]   tx_pattern_select,
   input  wire logic [1:0]         jitter_attenuator_select,
   input  wire logic [NCH-1:0]     rx_monitor_gain_select,
   input  wire logic [2*NCH-1:0]   loopback_select,
   input  wire logic               driver_tristate_enable,
   input  wire logic               rx_clock_edge_select,
   output logic      [2*NCH-1:0]   tx_source,
   output logic      [NCH-1:0]     tx_power_down,
   output logic      [NCH-1:0]     mon_gain_26db,
   output logic      [NCH-1:0]     analog_loopback,
   output logic      [NCH-1:0]     digital_loopback,
   output logic      [NCH-1:0]     remote_loopback,
   output logic                    inband_loopback_enable,
   output logic      [NCH-1:0]     line_driver_enable,
   output logic                    rx_clk_falling_edge,
   output logic                    ja_enable,
   output logic                    ja_in_tx_path,
   output logic                    ja_narrow_bw,
   output logic      [7:0]         ja_fifo_depth
);

   localparam int PW = hmcpd_pkg::HMCPD_PIN_W;

   logic [PW-1:0]  pin_raw;
   logic [PW-1:0]  pin_s1;
   logic [PW-1:0]  pin_s2;
   logic [PW-1:0]  pin_s3;
   logic [PW-1:0]  pin_filt;
   logic           hw_active;
   logic [31:0]    ctrl;
   logic [4:0]     ch_reg [NCH];
   logic [1:0]     eff_pat [NCH];
   logic [1:0]     eff_lb [NCH];
   logic [NCH-1:0] eff_gain;
   logic [1:0]     eff_ja;
   logic           eff_tristate;
   logic           eff_edge;
   logic           eff_inband;
   logic [31:0]    eff_word;
   logic           setup;
   logic           wr_done;
   logic [31:0]    next_prdata;
   logic           next_pslverr;
   logic [3:0]     lb_onehot [NCH];

   function automatic logic [3:0] decode_loop(input logic [1:0] sel);
      unique case (sel)
         hmcpd_pkg::HMCPD_LB_NONE:    decode_loop = 4'h0;
         hmcpd_pkg::HMCPD_LB_ANALOG:  decode_loop = 4'h1;
         hmcpd_pkg::HMCPD_LB_DIGITAL: decode_loop = 4'h2;
         hmcpd_pkg::HMCPD_LB_REMOTE:  decode_loop = 4'h4;
      endcase
   endfunction : decode_loop

   function automatic int ch_index(input logic [7:0] addr);
      ch_index = -1;
      for (int c = 0; c < NCH; c++) begin
         if (addr == 8'(hmcpd_pkg::HMCPD_CH0_OFS + c * hmcpd_pkg::HMCPD_CH_STRIDE)) begin
            ch_index = c;
         end
      end
   endfunction : ch_index

   // Strap capture. Straps are asynchronous to pclk, so a change is believed only
   // once the second and third stages agree; a one-cycle glitch never reaches the
   // decoded settings.
   assign pin_raw = {loopback_select, tx_pattern_select, rx_monitor_gain_select,
                     jitter_attenuator_select, rx_clock_edge_select,
                     driver_tristate_enable, hw_mode_select};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_filt <= '0;
      end else begin
         for (int i = 0; i < PW; i++) begin
            if (pin_s2[i] == pin_s3[i]) begin
               pin_filt[i] <= pin_s3[i];
            end
         end
      end
   end

   assign hw_active = pin_filt[hmcpd_pkg::HMCPD_PIN_HW];

   // Source of every setting but in-band loopback: straps in hardware mode, registers otherwise.
   always_comb begin
      eff_ja       = hw_active ? pin_filt[hmcpd_pkg::HMCPD_PIN_JA_LSB +: 2]
                               : ctrl[hmcpd_pkg::HMCPD_CTRL_JA_LSB +: 2];
      eff_tristate = hw_active ? pin_filt[hmcpd_pkg::HMCPD_PIN_TRISTATE]
                               : ctrl[hmcpd_pkg::HMCPD_CTRL_TRISTATE];
      eff_edge     = hw_active ? pin_filt[hmcpd_pkg::HMCPD_PIN_EDGE]
                               : ctrl[hmcpd_pkg::HMCPD_CTRL_EDGE];
      // Code-activated loopback exists only under software control.
      eff_inband   = !hw_active && ctrl[hmcpd_pkg::HMCPD_CTRL_INBAND];
      for (int c = 0; c < NCH; c++) begin
         eff_pat[c]  = hw_active ? pin_filt[hmcpd_pkg::HMCPD_PIN_PAT_LSB + 2*c +: 2]
                                 : ch_reg[c][hmcpd_pkg::HMCPD_CH_PAT_LSB +: 2];
         eff_lb[c]   = hw_active ? pin_filt[hmcpd_pkg::HMCPD_PIN_LB_LSB + 2*c +: 2]
                                 : ch_reg[c][hmcpd_pkg::HMCPD_CH_LB_LSB +: 2];
         eff_gain[c] = hw_active ? pin_filt[hmcpd_pkg::HMCPD_PIN_GAIN_LSB + c]
                                 : ch_reg[c][hmcpd_pkg::HMCPD_CH_GAIN];
      end
   end

   always_comb begin
      eff_word    = '0;
      eff_word[0 +: 2] = eff_ja;
      eff_word[2] = eff_tristate;
      eff_word[3] = eff_edge;
      eff_word[4] = eff_inband;
      eff_word[5] = hw_active;
      for (int c = 0; c < NCH; c++) begin
         eff_word[hmcpd_pkg::HMCPD_EFF_CH_LSB + c*hmcpd_pkg::HMCPD_EFF_CH_STEP +: 5] =
            {eff_gain[c], eff_lb[c], eff_pat[c]};
      end
   end

   // A function result cannot be bit-selected, so each channel's loopback code is
   // expanded here once and the flip-flops below pick single bits from it.
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         lb_onehot[c] = decode_loop(eff_lb[c]);
      end
   end

   // Per channel datapath controls.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_source        <= '0;
         tx_power_down    <= '0;
         mon_gain_26db    <= '0;
         analog_loopback  <= '0;
         digital_loopback <= '0;
         remote_loopback  <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            tx_source[2*c +: 2] <= eff_pat[c];
            tx_power_down[c]    <= (eff_pat[c] == hmcpd_pkg::HMCPD_TX_PWRDN);
            mon_gain_26db[c]    <= eff_gain[c];
            analog_loopback[c]  <= lb_onehot[c][0];
            digital_loopback[c] <= lb_onehot[c][1];
            remote_loopback[c]  <= lb_onehot[c][2];
         end
      end
   end

   // Global controls shared by both channels.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_driver_enable     <= '0;
         rx_clk_falling_edge    <= 1'b0;
         inband_loopback_enable <= 1'b0;
      end else begin
         line_driver_enable     <= {NCH{!eff_tristate}};
         rx_clk_falling_edge    <= eff_edge;
         inband_loopback_enable <= eff_inband;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ja_enable     <= 1'b0;
         ja_in_tx_path <= 1'b0;
         ja_narrow_bw  <= 1'b0;
         ja_fifo_depth <= '0;
      end else begin
         unique case (eff_ja)
            hmcpd_pkg::HMCPD_JA_OFF: begin
               ja_enable     <= 1'b0;
               ja_in_tx_path <= 1'b0;
               ja_narrow_bw  <= 1'b0;
               ja_fifo_depth <= '0;
            end
            hmcpd_pkg::HMCPD_JA_RX_BROAD: begin
               ja_enable     <= 1'b1;
               ja_in_tx_path <= 1'b0;
               ja_narrow_bw  <= 1'b0;
               ja_fifo_depth <= hmcpd_pkg::HMCPD_FIFO_BROAD;
            end
            hmcpd_pkg::HMCPD_JA_RX_NARROW: begin
               ja_enable     <= 1'b1;
               ja_in_tx_path <= 1'b0;
               ja_narrow_bw  <= 1'b1;
               ja_fifo_depth <= hmcpd_pkg::HMCPD_FIFO_NARROW;
            end
            hmcpd_pkg::HMCPD_JA_TX_NARROW: begin
               ja_enable     <= 1'b1;
               ja_in_tx_path <= 1'b1;
               ja_narrow_bw  <= 1'b1;
               ja_fifo_depth <= hmcpd_pkg::HMCPD_FIFO_NARROW;
            end
         endcase
      end
   end

   // APB slave. pready is raised during the access phase that follows each setup
   // cycle, so every transfer takes exactly two cycles with no wait state.
   assign setup   = psel && !penable;
   assign wr_done = psel && penable && pready && pwrite && !pslverr;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= hmcpd_pkg::HMCPD_CTRL_RESET;
         for (int c = 0; c < NCH; c++) begin
            ch_reg[c] <= hmcpd_pkg::HMCPD_CH_RESET;
         end
      end else if (wr_done) begin
         if (paddr == hmcpd_pkg::HMCPD_CTRL_OFS) begin
            ctrl <= pwdata & hmcpd_pkg::HMCPD_CTRL_MASK;
         end
         for (int c = 0; c < NCH; c++) begin
            if (ch_index(paddr) == c) begin
               ch_reg[c] <= pwdata[4:0];
            end
         end
      end
   end

   always_comb begin
      next_prdata  = '0;
      next_pslverr = 1'b0;
      if (paddr == hmcpd_pkg::HMCPD_CTRL_OFS) begin
         next_prdata = ctrl;
      end else if (ch_index(paddr) >= 0) begin
         for (int c = 0; c < NCH; c++) begin
            if (ch_index(paddr) == c) begin
               next_prdata = {27'h0000000, ch_reg[c]};
            end
         end
      end else if (paddr == hmcpd_pkg::HMCPD_STATUS_OFS) begin
         next_prdata = {{(32-PW){1'b0}}, pin_filt};
      end else if (paddr == hmcpd_pkg::HMCPD_EFFECT_OFS) begin
         next_prdata = eff_word;
      end else begin
         next_pslverr = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setup;
         pslverr <= setup && next_pslverr;
         prdata  <= (setup && !pwrite) ? next_prdata : 32'h0000_0000;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence seq_soft_steady;
      !hw_active [*2];
   endsequence

   sequence seq_hw_steady;
      hw_active [*2];
   endsequence

   AST_PAT_PWRDN: assert property (eff_pat[0] == hmcpd_pkg::HMCPD_TX_PWRDN |=>
      tx_power_down[0] && tx_source[1:0] == hmcpd_pkg::HMCPD_TX_PWRDN)
      else $error("power down pattern not decoded");
   AST_JA_OFF: assert property (eff_ja == hmcpd_pkg::HMCPD_JA_OFF |=>
      !ja_enable && ja_fifo_depth == 8'h00)
      else $error("attenuator not disabled");
   AST_JA_RX_BROAD: assert property (eff_ja == hmcpd_pkg::HMCPD_JA_RX_BROAD |=>
      ja_enable && !ja_in_tx_path && !ja_narrow_bw && ja_fifo_depth == 8'h40)
      else $error("broad receive attenuator wrong");
   AST_JA_RX_NARROW: assert property (eff_ja == hmcpd_pkg::HMCPD_JA_RX_NARROW |=>
      ja_enable && !ja_in_tx_path && ja_narrow_bw && ja_fifo_depth == 8'h80)
      else $error("narrow receive attenuator wrong");
   AST_JA_TX_NARROW: assert property (eff_ja == hmcpd_pkg::HMCPD_JA_TX_NARROW |=>
      ja_enable && ja_in_tx_path && ja_narrow_bw && ja_fifo_depth == 8'h80)
      else $error("transmit attenuator wrong");
   AST_GAIN: assert property (seq_hw_steady |->
      mon_gain_26db == $past(pin_filt[hmcpd_pkg::HMCPD_PIN_GAIN_LSB +: NCH]))
      else $error("monitor gain not following strap");
   AST_LOOP_REMOTE: assert property (eff_lb[1] == hmcpd_pkg::HMCPD_LB_REMOTE |=>
      remote_loopback[1] && !analog_loopback[1] && !digital_loopback[1])
      else $error("remote loopback not decoded");
   AST_LOOP_ANALOG: assert property (eff_lb[0] == hmcpd_pkg::HMCPD_LB_ANALOG |=>
      analog_loopback[0] && !digital_loopback[0] && !remote_loopback[0])
      else $error("analog loopback not decoded");
   AST_LOOP_DIGITAL: assert property (eff_lb[0] == hmcpd_pkg::HMCPD_LB_DIGITAL |=>
      digital_loopback[0] && !analog_loopback[0] && !remote_loopback[0])
      else $error("digital loopback not decoded");
   AST_NO_INBAND_HW: assert property (hw_active |=> !inband_loopback_enable)
      else $error("in-band loopback allowed in hardware mode");
   AST_DRV_ON: assert property (!eff_tristate |=> line_driver_enable == {NCH{1'b1}})
      else $error("drivers not enabled");
   AST_DRV_HIZ: assert property (eff_tristate |=> line_driver_enable == '0)
      else $error("drivers not in high impedance");
   AST_EDGE_RISE: assert property (hw_active && !eff_edge |=> !rx_clk_falling_edge)
      else $error("rising edge not selected");
   AST_EDGE_FALL: assert property (hw_active && eff_edge |=> rx_clk_falling_edge)
      else $error("falling edge not selected");
   AST_SYNC_HOLD: assert property ($rose(hw_active) |->
      $past(hw_mode_select, 3) && $past(hw_mode_select, 4))
      else $error("hardware mode entered without a held strap");
   AST_SW_GOVERNS: assert property (seq_soft_steady |->
      tx_source[1:0] == $past(ch_reg[0][1:0]))
      else $error("register setting not applied in software mode");

endmodule : hmcpd_top

// ---- verilog/hmcpd_pkg.sv ----
package hmcpd_pkg;

   localparam int HMCPD_NCH = 2;

   // Register byte offsets on the APB side.
   localparam logic [7:0] HMCPD_CTRL_OFS   = 8'h00;
   localparam logic [7:0] HMCPD_CH0_OFS    = 8'h04;
   localparam logic [7:0] HMCPD_CH_STRIDE  = 8'h04;
   localparam logic [7:0] HMCPD_STATUS_OFS = 8'h10;
   localparam logic [7:0] HMCPD_EFFECT_OFS = 8'h14;

   // Software control register fields.
   localparam int HMCPD_CTRL_INBAND  = 0;
   localparam int HMCPD_CTRL_TRISTATE = 1;
   localparam int HMCPD_CTRL_EDGE    = 2;
   localparam int HMCPD_CTRL_JA_LSB  = 4;
   localparam logic [31:0] HMCPD_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] HMCPD_CTRL_MASK  = 32'h0000_0037;

   // Per channel register fields.
   localparam int HMCPD_CH_PAT_LSB = 0;
   localparam int HMCPD_CH_LB_LSB  = 2;
   localparam int HMCPD_CH_GAIN    = 4;
   localparam logic [4:0] HMCPD_CH_RESET = 5'h00;

   // Effective settings word: globals low, one byte per channel from bit 8.
   localparam int HMCPD_EFF_CH_LSB  = 8;
   localparam int HMCPD_EFF_CH_STEP = 8;

   // Layout of the synchronised strap vector.
   localparam int HMCPD_PIN_W        = 15;
   localparam int HMCPD_PIN_HW       = 0;
   localparam int HMCPD_PIN_TRISTATE = 1;
   localparam int HMCPD_PIN_EDGE     = 2;
   localparam int HMCPD_PIN_JA_LSB   = 3;
   localparam int HMCPD_PIN_GAIN_LSB = 5;
   localparam int HMCPD_PIN_PAT_LSB  = 7;
   localparam int HMCPD_PIN_LB_LSB   = 11;

   localparam logic [7:0] HMCPD_FIFO_BROAD  = 8'h40;
   localparam logic [7:0] HMCPD_FIFO_NARROW = 8'h80;

   typedef enum logic [1:0] {
      HMCPD_TX_NORMAL = 2'h0,
      HMCPD_TX_ONES   = 2'h1,
      HMCPD_TX_PRBS   = 2'h2,
      HMCPD_TX_PWRDN  = 2'h3
   } hmcpd_tx_src_t;

   typedef enum logic [1:0] {
      HMCPD_LB_NONE    = 2'h0,
      HMCPD_LB_ANALOG  = 2'h1,
      HMCPD_LB_DIGITAL = 2'h2,
      HMCPD_LB_REMOTE  = 2'h3
   } hmcpd_lb_t;

   typedef enum logic [1:0] {
      HMCPD_JA_OFF       = 2'h0,
      HMCPD_JA_RX_BROAD  = 2'h1,
      HMCPD_JA_RX_NARROW = 2'h2,
      HMCPD_JA_TX_NARROW = 2'h3
   } hmcpd_ja_t;

endpackage : hmcpd_pkg

// ---- tb/hmcpd_strap_model.sv ----
`timescale 1ns/1ps
module hmcpd_strap_model (
   input  wire logic       pclk,
   output logic            hw_mode_select,
   output logic [3:0]      tx_pattern_select,
   output logic [1:0]      jitter_attenuator_select,
   output logic [1:0]      rx_monitor_gain_select,
   output logic [3:0]      loopback_select,
   output logic            driver_tristate_enable,
   output logic            rx_clock_edge_select
);
   // Board straps are static levels that start low and move only when asked to.
   initial begin
      hw_mode_select = 1'b0;
      tx_pattern_select = 4'h0;
      jitter_attenuator_select = 2'h0;
      rx_monitor_gain_select = 2'h0;
      loopback_select = 4'h0;
      driver_tristate_enable = 1'b0;
      rx_clock_edge_select = 1'b0;
   end

   // Both bits of a two-bit select change at the same edge, as a real strap bank would.
   task automatic apply(input logic hw, input logic [3:0] pat, input logic [1:0] ja,
                        input logic [1:0] gain, input logic [3:0] lb, input logic tz,
                        input logic edg);
      @(posedge pclk);
      hw_mode_select <= hw;
      tx_pattern_select <= pat;
      jitter_attenuator_select <= ja;
      rx_monitor_gain_select <= gain;
      loopback_select <= lb;
      driver_tristate_enable <= tz;
      rx_clock_edge_select <= edg;
   endtask : apply
endmodule : hmcpd_strap_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr;
   logic        hw_mode_select, driver_tristate_enable, rx_clock_edge_select;
   logic [3:0]  tx_pattern_select, loopback_select, tx_source;
   logic [1:0]  jitter_attenuator_select, rx_monitor_gain_select;
   logic [1:0]  tx_power_down, mon_gain_26db, analog_loopback, digital_loopback;
   logic [1:0]  remote_loopback, line_driver_enable;
   logic        inband_loopback_enable, rx_clk_falling_edge, ja_enable, ja_in_tx_path;
   logic        ja_narrow_bw;
   logic [7:0]  ja_fifo_depth;
   logic [31:0] rd;
   logic        er;
   int          errors = 0;
   int          cmp_count = 0;

   hmcpd_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .hw_mode_select, .tx_pattern_select, .jitter_attenuator_select,
      .rx_monitor_gain_select, .loopback_select, .driver_tristate_enable,
      .rx_clock_edge_select, .tx_source, .tx_power_down, .mon_gain_26db, .analog_loopback,
      .digital_loopback, .remote_loopback, .inband_loopback_enable, .line_driver_enable,
      .rx_clk_falling_edge, .ja_enable, .ja_in_tx_path, .ja_narrow_bw, .ja_fifo_depth);

   hmcpd_strap_model straps (.pclk, .hw_mode_select, .tx_pattern_select,
      .jitter_attenuator_select, .rx_monitor_gain_select, .loopback_select,
      .driver_tristate_enable, .rx_clock_edge_select);

   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         errors++;
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0000_0000);
      `CHK("read data", e, rd)
      `CHK("read error", ee, er)
   endtask : rd_chk

   // Strap changes need the synchroniser and filter; six edges covers the stated five.
   task automatic settle;
      repeat (6) @(posedge pclk);
      #1;
   endtask : settle

   task automatic check_eff(input logic [3:0] pat, input logic [1:0] ja, input logic [1:0] gain,
                            input logic [3:0] lb, input logic tz, input logic edg,
                            input logic inb);
      logic [1:0] pd, an, dg, rm;
      logic [7:0] dep;
      for (int c = 0; c < 2; c++) begin
         pd[c] = (pat[2*c+:2] == 2'h3);
         an[c] = (lb[2*c+:2] == 2'h1);
         dg[c] = (lb[2*c+:2] == 2'h2);
         rm[c] = (lb[2*c+:2] == 2'h3);
      end
      dep = (ja == 2'h0) ? 8'h00 : (ja == 2'h1) ? 8'h40 : 8'h80;
      `CHK("tx_source", pat, tx_source)
      `CHK("tx_power_down", pd, tx_power_down)
      `CHK("loopbacks", {an, dg, rm}, {analog_loopback, digital_loopback, remote_loopback})
      `CHK("mon_gain_26db", gain, mon_gain_26db)
      `CHK("ja_enable", ja != 2'h0, ja_enable)
      `CHK("ja_path_bw", {ja == 2'h3, ja[1]}, {ja_in_tx_path, ja_narrow_bw})
      `CHK("ja_fifo_depth", dep, ja_fifo_depth)
      `CHK("line_driver_enable", {2{~tz}}, line_driver_enable)
      `CHK("rx_clk_falling_edge", edg, rx_clk_falling_edge)
      `CHK("inband_loopback_enable", inb, inband_loopback_enable)
   endtask : check_eff

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (10) @(posedge pclk);
      #1;
      `CHK("outputs in reset", 14'h0000, {line_driver_enable, ja_fifo_depth, tx_source})
      @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(8'h00, 32'h0000_0000, 1'b0);
      rd_chk(8'h04, 32'h0000_0000, 1'b0);
      rd_chk(8'h08, 32'h0000_0000, 1'b0);
      rd_chk(8'h20, 32'h0000_0000, 1'b1);
      settle();
      check_eff(4'h0, 2'h0, 2'h0, 4'h0, 1'b0, 1'b0, 1'b0);
      $display("test reset done");

      // Software mode: registers govern while straps sit on conflicting values.
      straps.apply(1'b0, 4'hf, 2'h0, 2'h2, 4'h0, 1'b0, 1'b0);
      apb(1'b1, 8'h00, 32'h0000_0037);
      apb(1'b1, 8'h04, 32'h0000_001e);
      apb(1'b1, 8'h08, 32'h0000_0005);
      rd_chk(8'h00, 32'h0000_0037, 1'b0);
      rd_chk(8'h04, 32'h0000_001e, 1'b0);
      settle();
      check_eff(4'h6, 2'h3, 2'h1, 4'h7, 1'b1, 1'b1, 1'b1);
      $display("test software mode done");

      // Hardware mode walks every code; in-band stays off although the register asks for it.
      for (int k = 0; k < 4; k++) begin
         straps.apply(1'b1, {~k[1:0], k[1:0]}, k[1:0], k[1:0], {k[1:0], ~k[1:0]}, k[0], k[1]);
         settle();
         check_eff({~k[1:0], k[1:0]}, k[1:0], k[1:0], {k[1:0], ~k[1:0]}, k[0], k[1], 1'b0);
      end
      $display("test hardware codes done");

      // A one-sample strap pulse must be filtered out.
      straps.apply(1'b1, 4'hc, 2'h3, 2'h3, 4'hc, 1'b1, 1'b1);
      straps.apply(1'b1, 4'h3, 2'h3, 2'h3, 4'hc, 1'b1, 1'b1);
      for (int i = 0; i < 6; i++) begin
         @(posedge pclk);
         #1;
         `CHK("tx_source glitch", 4'h3, tx_source)
      end
      straps.apply(1'b1, 4'hc, 2'h3, 2'h3, 4'h3, 1'b1, 1'b1);
      settle();
      check_eff(4'hc, 2'h3, 2'h3, 4'h3, 1'b1, 1'b1, 1'b0);
      apb(1'b1, 8'h10, 32'hffff_ffff);
      `CHK("status write error", 1'b0, er)
      rd_chk(8'h10, {17'h00000, 4'h3, 4'hc, 2'h3, 2'h3, 1'b1, 1'b1, 1'b1}, 1'b0);
      $display("test strap filter done");

      // Leaving hardware mode hands control back to the registers.
      straps.apply(1'b0, 4'hc, 2'h3, 2'h3, 4'h3, 1'b1, 1'b1);
      apb(1'b1, 8'h00, 32'h0000_0010);
      settle();
      check_eff(4'h6, 2'h1, 2'h1, 4'h7, 1'b0, 1'b0, 1'b0);
      rd_chk(8'h08, 32'h0000_0005, 1'b0);
      rd_chk(8'h14, 32'h0005_1e01, 1'b0);
      $display("test mode return done");
      close_out();
   end
endmodule : tb
